// ===== shared/sfc_consts.vh
// Constants shared by the serial frame check unit
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// CRC accumulator seed and reflected polynomial
`define SFC_CRC_SEED     16'hffff
`define SFC_CRC_POLY     16'ha001
// Bit steps applied to each merged byte
`define SFC_BIT_STEPS    8
// Frame terminator characters of ASCII mode
`define SFC_CHAR_CR      8'h0d
`define SFC_CHAR_LF      8'h0a
// Hex digit characters
`define SFC_CHAR_ZERO    8'h30
`define SFC_CHAR_A_LESS10 8'h37
// Silent line interval: 10 ms at the 50 MHz clock, sized for the 20-bit counter
`define SFC_SILENCE_CYC  20'd500000
// Check field sender states
`define SFC_TX_IDLE      3'h0
`define SFC_TX_CHK0      3'h1
`define SFC_TX_CHK1      3'h2
`define SFC_TX_CHK2      3'h3
`define SFC_TX_CHK3      3'h4

`endif

// ===== verilog/sfc_crc_byte.v
// One byte of the reflected 16-bit CRC: merge then eight bit steps
`timescale 1ns/1ps
`include "sfc_consts.vh"

module sfc_crc_byte #(
   parameter [15:0] POLY = `SFC_CRC_POLY   // Reflected polynomial
) (
   input  wire [15:0] crcIn,                // Accumulator before the byte
   input  wire [7:0]  dataIn,               // Frame byte to merge
   output wire [15:0] crcOut                // Accumulator after the byte
);

   // Stage k holds the value after k bit steps
   wire [15:0] stage [0:`SFC_BIT_STEPS];

   // Low half takes the byte, high half untouched
   assign stage[0] = {crcIn[15:8], crcIn[7:0] ^ dataIn};

   // Shift right, fold in the polynomial when a one drops out
   genvar i;
   generate
      for (i = 0; i < `SFC_BIT_STEPS; i = i + 1) begin : g_step
         assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ POLY) : (stage[i] >> 1);
      end
   endgenerate

   // Exactly eight steps before the next byte
   assign crcOut = stage[`SFC_BIT_STEPS];

endmodule // sfc_crc_byte

// ===== verilog/sfc_frame_check.v
// Frame check unit: LRC and CRC generation and checking for the serial slave port
`timescale 1ns/1ps
`include "sfc_consts.vh"

module sfc_frame_check #(
   parameter        CNT_W       = 20,                // Width of the silence counter
   parameter [19:0] SILENCE_CYC = `SFC_SILENCE_CYC   // Silent interval in cycles
) (
   input  wire       clk_sys,        // System clock
   input  wire       sys_rst,        // Asynchronous reset, active high
   input  wire       asciiMode,      // 1: ASCII with LRC, 0: RTU with CRC
   input  wire       rxStart,        // Pulse: start of a received frame
   input  wire       rxByteValid,    // Pulse: received frame byte present
   input  wire [7:0] rxByte,         // Received byte, check field included
   input  wire       rxEnd,          // Pulse: end of ASCII frame
   input  wire       errClear,       // Pulse: clear the error flag
   output reg        frameOk_r,      // Pulse: received frame passed
   output reg        frameBad_r,     // Pulse: received frame discarded
   output reg        commErr_r,      // Sticky communication error
   output wire       lineQuiet,      // Silent interval has elapsed
   input  wire       txStart,        // Pulse: start of a sent frame
   input  wire       txByteValid,    // Sent frame byte offered
   input  wire [7:0] txByte,         // Sent frame byte
   output wire       txReady,        // Frame byte may be taken
   input  wire       txSeal,         // Pulse: append the check field
   output wire       chkValid,       // Check character offered
   output reg  [7:0] chkData_r,      // Check character
   input  wire       chkReady        // Check character taken
);

   // Hex digit of a nibble as an uppercase ASCII character
   function [7:0] hexChar;
      input [3:0] nib;
      begin
         if (nib < 4'ha) begin
            hexChar = `SFC_CHAR_ZERO + {4'h0, nib};
         end else begin
            hexChar = `SFC_CHAR_A_LESS10 + {4'h0, nib};
         end
      end
   endfunction

   // Receive side state
   reg         rxOpen_r;        // Frame in progress
   reg  [15:0] rxCrc_r;         // Receive CRC accumulator
   reg  [7:0]  rxSum_r;         // Receive byte sum, carries dropped
   reg  [7:0]  hold0_r;         // Newest held byte
   reg  [7:0]  hold1_r;         // Older held byte
   reg  [1:0]  holdCnt_r;       // Bytes held, saturates at two
   reg  [CNT_W-1:0] quietCnt_r; // Cycles since last line activity

   // Transmit side state
   reg  [2:0]  txState_r;       // Check field sender state
   reg  [15:0] txCrc_r;         // Transmit CRC accumulator
   reg  [7:0]  txSum_r;         // Transmit byte sum

   // Combinational helpers
   wire [15:0] rxCrcNxt;        // Receive CRC after folding
   wire [15:0] txCrcNxt;        // Transmit CRC after the byte
   wire [7:0]  foldByte;        // Byte leaving the hold stage
   wire        foldEn;          // Hold stage is full
   wire        rxAcc;           // Received byte accepted
   wire        rtuEnd;          // RTU frame closed by silence
   wire        endNow;          // Frame closes this cycle
   wire [7:0]  rxLrc;           // LRC of received bytes
   wire [7:0]  txLrc;           // LRC of sent bytes
   wire        goodAscii;       // ASCII check field matches
   wire        goodRtu;         // RTU check field matches
   wire        txAcc;           // Frame byte taken
   wire        chkAcc;          // Check character taken

   // ASCII holds back one check byte, RTU two
   assign foldByte = asciiMode ? hold0_r : hold1_r;
   assign foldEn   = asciiMode ? (holdCnt_r != 2'h0) : (holdCnt_r == 2'h2);

   // RTU frames open on any byte, ASCII only after a start mark
   assign rxAcc  = rxByteValid && (rxOpen_r || !asciiMode);
   assign rtuEnd = !asciiMode && lineQuiet;
   assign endNow = rxOpen_r && (asciiMode ? rxEnd : rtuEnd);

   // Two's complement of the low eight bits of the sum
   assign rxLrc = 8'h00 - rxSum_r;
   assign txLrc = 8'h00 - txSum_r;

   // Compare recomputed code with the held check field
   assign goodAscii = (holdCnt_r != 2'h0) && (rxLrc == hold0_r);
   assign goodRtu   = (holdCnt_r == 2'h2) && (rxCrc_r == {hold0_r, hold1_r});

   // Transmit handshakes
   assign txReady  = (txState_r == `SFC_TX_IDLE);
   assign txAcc    = txByteValid && txReady;
   assign chkValid = (txState_r != `SFC_TX_IDLE);
   assign chkAcc   = chkValid && chkReady;

   // Silent interval reached
   assign lineQuiet = (quietCnt_r == SILENCE_CYC[CNT_W-1:0]);

   // CRC datapaths
   sfc_crc_byte #(
      .POLY   (`SFC_CRC_POLY)
   ) u_rx_crc (
      .crcIn  (rxCrc_r),
      .dataIn (foldByte),
      .crcOut (rxCrcNxt)
   );

   sfc_crc_byte #(
      .POLY   (`SFC_CRC_POLY)
   ) u_tx_crc (
      .crcIn  (txCrc_r),
      .dataIn (txByte),
      .crcOut (txCrcNxt)
   );

   // Silence counter, restarted by any byte on the line
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         quietCnt_r <= {CNT_W{1'b0}};
      end else if (rxByteValid || txAcc || chkAcc) begin
         quietCnt_r <= {CNT_W{1'b0}};
      end else if (!lineQuiet) begin
         quietCnt_r <= quietCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Receive accumulation and frame close
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rxOpen_r  <= 1'b0;
         rxCrc_r   <= `SFC_CRC_SEED;
         rxSum_r   <= 8'h00;
         hold0_r   <= 8'h00;
         hold1_r   <= 8'h00;
         holdCnt_r <= 2'h0;
      end else if (rxStart || endNow) begin
         // Reseed for the next frame
         rxCrc_r   <= `SFC_CRC_SEED;
         rxSum_r   <= 8'h00;
         hold1_r   <= 8'h00;
         if (endNow && !asciiMode && rxByteValid) begin
            // Byte after silence opens the next RTU frame
            rxOpen_r  <= 1'b1;
            hold0_r   <= rxByte;
            holdCnt_r <= 2'h1;
         end else begin
            rxOpen_r  <= rxStart;
            hold0_r   <= 8'h00;
            holdCnt_r <= 2'h0;
         end
      end else if (rxAcc) begin
         // Shift the hold stage, fold the leaving byte
         rxOpen_r <= 1'b1;
         hold0_r  <= rxByte;
         hold1_r  <= hold0_r;
         if (holdCnt_r != 2'h2) begin
            holdCnt_r <= holdCnt_r + 2'h1;
         end
         if (foldEn) begin
            rxCrc_r <= rxCrcNxt;
            rxSum_r <= rxSum_r + foldByte;
         end
      end
   end

   // Verdict pulses and sticky error
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         frameOk_r  <= 1'b0;
         frameBad_r <= 1'b0;
         commErr_r  <= 1'b0;
      end else begin
         frameOk_r  <= endNow && (asciiMode ? goodAscii : goodRtu);
         frameBad_r <= endNow && !(asciiMode ? goodAscii : goodRtu);
         if (endNow && !(asciiMode ? goodAscii : goodRtu)) begin
            // Set wins over a clear in the same cycle
            commErr_r <= 1'b1;
         end else if (errClear) begin
            commErr_r <= 1'b0;
         end
      end
   end

   // Transmit accumulation and check field sender
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         txState_r <= `SFC_TX_IDLE;
         txCrc_r   <= `SFC_CRC_SEED;
         txSum_r   <= 8'h00;
         chkData_r <= 8'h00;
      end else if (txStart) begin
         // New frame aborts any check field in flight
         txState_r <= `SFC_TX_IDLE;
         txCrc_r   <= `SFC_CRC_SEED;
         txSum_r   <= 8'h00;
      end else begin
         case (txState_r)
            `SFC_TX_IDLE: begin
               if (txAcc) begin
                  txCrc_r <= txCrcNxt;
                  txSum_r <= txSum_r + txByte;
               end else if (txSeal) begin
                  txState_r <= `SFC_TX_CHK0;
                  // LRC high nibble first, CRC low byte first
                  chkData_r <= asciiMode ? hexChar(txLrc[7:4]) : txCrc_r[7:0];
               end
            end
            `SFC_TX_CHK0: begin
               if (chkAcc) begin
                  txState_r <= `SFC_TX_CHK1;
                  chkData_r <= asciiMode ? hexChar(txLrc[3:0]) : txCrc_r[15:8];
               end
            end
            `SFC_TX_CHK1: begin
               if (chkAcc) begin
                  if (asciiMode) begin
                     txState_r <= `SFC_TX_CHK2;
                     chkData_r <= `SFC_CHAR_CR;
                  end else begin
                     txState_r <= `SFC_TX_IDLE;
                     txCrc_r   <= `SFC_CRC_SEED;
                     txSum_r   <= 8'h00;
                  end
               end
            end
            `SFC_TX_CHK2: begin
               if (chkAcc) begin
                  txState_r <= `SFC_TX_CHK3;
                  chkData_r <= `SFC_CHAR_LF;
               end
            end
            `SFC_TX_CHK3: begin
               if (chkAcc) begin
                  txState_r <= `SFC_TX_IDLE;
                  txCrc_r   <= `SFC_CRC_SEED;
                  txSum_r   <= 8'h00;
               end
            end
            default: begin
               txState_r <= `SFC_TX_IDLE;
            end
         endcase
      end
   end

endmodule // sfc_frame_check

// ===== test/sfc_frame_check_properties.sv
// Concurrent checks on the frame check unit ports
`timescale 1ns/1ps
module sfc_frame_check_properties (
   input wire       clk_sys,     // System clock
   input wire       sys_rst,     // Reset, active high
   input wire       asciiMode,   // Frame kind select
   input wire       rxByteValid, // Received byte strobe
   input wire       errClear,    // Error clear pulse
   input wire       frameOk_r,   // Frame passed pulse
   input wire       frameBad_r,  // Frame failed pulse
   input wire       commErr_r,   // Sticky error
   input wire       lineQuiet,   // Line silent
   input wire       txStart,     // Sender reseed
   input wire       txByteValid, // Sent byte offered
   input wire       txReady,     // Sender idle
   input wire       txSeal,      // Check field request
   input wire       chkValid,    // Check character offered
   input wire [7:0] chkData_r,   // Check character
   input wire       chkReady     // Check character taken
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_OK_BAD: assert property (!(frameOk_r && frameBad_r))
      else $error("pass and fail pulse together");
   AST_OK_PULSE: assert property (frameOk_r |=> !frameOk_r)
      else $error("pass pulse too long");
   AST_BAD_ERR: assert property (frameBad_r |-> commErr_r)
      else $error("fail pulse without error flag");
   AST_ERR_CAUSE: assert property ($rose(commErr_r) |-> frameBad_r)
      else $error("error flag without fail pulse");
   AST_ERR_HOLD: assert property (commErr_r && !errClear |=> commErr_r)
      else $error("error flag dropped");
   AST_ERR_CLR: assert property (errClear ##1 !frameBad_r |-> !commErr_r)
      else $error("error flag not cleared");
   AST_QUIET: assert property (rxByteValid |=> !lineQuiet)
      else $error("line quiet right after a byte");
   AST_SEAL: assert property (txSeal && txReady && !txStart && !txByteValid |=> chkValid)
      else $error("no check character after seal");
   AST_HOLD: assert property (chkValid && !chkReady && !txStart |=> chkValid && $stable(chkData_r))
      else $error("check character not held");
   AST_BUSY: assert property (chkValid |-> !txReady)
      else $error("sender ready while check field pending");
   AST_RTU_TWO: assert property (chkValid && chkReady && !asciiMode && !txStart
      ##1 chkValid && chkReady && !txStart |=> txReady && !chkValid)
      else $error("more than two check bytes in binary mode");
   AST_ASC_END: assert property (chkValid && chkReady && asciiMode && chkData_r == 8'h0d && !txStart
      |=> chkValid && chkData_r == 8'h0a)
      else $error("line feed does not follow carriage return");
endmodule // sfc_frame_check_properties

bind sfc_frame_check sfc_frame_check_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .asciiMode(asciiMode), .rxByteValid(rxByteValid), .errClear(errClear), .frameOk_r(frameOk_r),
   .frameBad_r(frameBad_r), .commErr_r(commErr_r), .lineQuiet(lineQuiet), .txStart(txStart),
   .txByteValid(txByteValid), .txReady(txReady), .txSeal(txSeal), .chkValid(chkValid),
   .chkData_r(chkData_r), .chkReady(chkReady));

// ===== test/sfc_host_model.sv
// Host model that takes check characters with random stalls
`timescale 1ns/1ps
module sfc_host_model (
   input  wire       clk_sys,   // System clock
   input  wire       sys_rst,   // Reset, active high
   input  wire       chkValid,  // Check character offered
   input  wire [7:0] chkData_r, // Check character
   output reg        chkReady = 1'b0 // Character taken
);
   logic [7:0] got [$];         // Characters collected in order
   // Take a character on valid and ready, then choose prompt or stalled acceptance
   always @(posedge clk_sys) begin
      if (!sys_rst && chkValid && chkReady) got.push_back(chkData_r);
      #2 chkReady <= ($urandom % 3) != 0;
   end
endmodule // sfc_host_model

// ===== test/sfc_frame_check_tb.sv
// Self-checking bench for the frame check unit
`timescale 1ns/1ps
`define CHK(n,e,a) begin checkCount++; if ((a) !== (e)) begin errTotal++; $display("unexpected %s exp %h got %h", n, e, a); end end
module sfc_frame_check_tb;
   logic clk_sys = 0, sys_rst = 1, asciiMode = 0, rxStart = 0, rxByteValid = 0, rxEnd = 0, errClear = 0;
   logic txStart = 0, txByteValid = 0, txSeal = 0, frameOk_r, frameBad_r, commErr_r, lineQuiet;
   logic txReady, chkValid, chkReady;
   logic [7:0] rxByte = 0, txByte = 0, chkData_r;
   logic [7:0] d [$], fr [$];   // Frame data, and data with check field
   int errTotal = 0, checkCount = 0, n;
   bit mode, bad;
   always #10 clk_sys = ~clk_sys;   // 50 MHz
   sfc_frame_check #(.CNT_W(20), .SILENCE_CYC(20'd20)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .asciiMode(asciiMode), .rxStart(rxStart), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxEnd(rxEnd),
      .errClear(errClear), .frameOk_r(frameOk_r), .frameBad_r(frameBad_r), .commErr_r(commErr_r),
      .lineQuiet(lineQuiet), .txStart(txStart), .txByteValid(txByteValid), .txByte(txByte),
      .txReady(txReady), .txSeal(txSeal), .chkValid(chkValid), .chkData_r(chkData_r), .chkReady(chkReady));
   sfc_host_model u_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .chkValid(chkValid),
      .chkData_r(chkData_r), .chkReady(chkReady));
   // Reference CRC over the first m bytes
   function automatic logic [15:0] crcOf(input logic [7:0] q [$], input int m);
      int c, i, j;
      c = 'hffff;
      for (i = 0; i < m; i++) begin
         c = c ^ q[i];
         for (j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 'ha001 : c >> 1;
      end
      return c[15:0];
   endfunction
   // Reference checksum over the first m bytes
   function automatic logic [7:0] lrcOf(input logic [7:0] q [$], input int m);
      int s, i;
      s = 0;
      for (i = 0; i < m; i++) s += q[i];
      return 8'h00 - s[7:0];
   endfunction
   // Uppercase hex digit
   function automatic logic [7:0] hx(input logic [3:0] h);
      return (h < 10) ? 8'h30 + h : 8'h37 + h;
   endfunction
   task automatic tick(); @(posedge clk_sys); #2; endtask
   // Append the check field, optionally spoiled
   task automatic mk(input bit asc, input bit spoil);
      logic [15:0] c;
      c = crcOf(d, d.size());
      fr = d;
      if (asc) fr.push_back(lrcOf(d, d.size()));
      else begin fr.push_back(c[7:0]); fr.push_back(c[15:8]); end
      if (spoil) fr[fr.size() - 1] ^= 8'h01;
   endtask
   // Receive frame fr and expect pass or fail
   task automatic rxFrame(input bit asc, input bit good);
      int i;
      asciiMode = asc;
      if (asc) begin rxStart = 1; tick(); rxStart = 0; end
      for (i = 0; i < fr.size(); i++) begin rxByteValid = 1; rxByte = fr[i]; tick(); end
      rxByteValid = 0; rxEnd = asc; tick(); rxEnd = 0;
      for (i = 0; i < 60 && !(frameOk_r || frameBad_r); i++) tick();
      `CHK("frameOk", good, frameOk_r)
      `CHK("frameBad", !good, frameBad_r)
      tick();
      `CHK("commErr", !good, commErr_r)
      errClear = 1; tick(); errClear = 0; tick();
      `CHK("commErr", 1'b0, commErr_r)
      repeat (24) tick();
      `CHK("lineQuiet", 1'b1, lineQuiet)
      $display("test rx mode %0d done", asc);
   endtask
   // Send data d and compare the check characters taken by the host
   task automatic txFrame(input bit asc);
      int i;
      logic [7:0] e [$];
      logic [15:0] c;
      logic [7:0] l;
      asciiMode = asc; u_host.got = {};
      txStart = 1; tick(); txStart = 0;
      `CHK("txReady", 1'b1, txReady)
      for (i = 0; i < d.size(); i++) begin txByteValid = 1; txByte = d[i]; tick(); end
      txByteValid = 0; txSeal = 1; tick(); txSeal = 0;
      c = crcOf(d, d.size()); l = lrcOf(d, d.size());
      if (asc) e = {hx(l[7:4]), hx(l[3:0]), 8'h0d, 8'h0a}; else e = {c[7:0], c[15:8]};
      for (i = 0; i < 200 && u_host.got.size() < e.size(); i++) tick();
      `CHK("chkCount", e.size(), u_host.got.size())
      foreach (e[k]) `CHK("chkChar", e[k], u_host.got[k])
      $display("test tx mode %0d done", asc);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin #(20 * 30000); errTotal++; complete_run(); end
   // Main sequence
   initial begin
      void'($urandom(51291));
      repeat (2) @(posedge clk_sys);
      #1 `CHK("chkValid", 1'b0, chkValid)
      `CHK("lineQuiet", 1'b0, lineQuiet)
      #1 sys_rst = 0;
      d = {8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h02};
      `CHK("crcModel", 16'h3794, crcOf(d, 6))
      mk(0, 0); rxFrame(0, 1);
      mk(0, 1); rxFrame(0, 0);
      txFrame(0);
      d = {8'h7f, 8'h03, 8'h05, 8'hc4, 8'h00, 8'h01};
      `CHK("lrcModel", 8'hb4, lrcOf(d, 6))
      mk(1, 0); rxFrame(1, 1);
      mk(1, 1); rxFrame(1, 0);
      txFrame(1);
      // Bad frame closing in the clear cycle: the error flag must still set
      mk(1, 1); asciiMode = 1; rxStart = 1; tick(); rxStart = 0;
      foreach (fr[k]) begin rxByteValid = 1; rxByte = fr[k]; tick(); end
      rxByteValid = 0; rxEnd = 1; errClear = 1; tick(); rxEnd = 0; errClear = 0;
      `CHK("frameBad", 1'b1, frameBad_r)
      `CHK("commErr", 1'b1, commErr_r)
      // Reset in mid-run clears the sticky flag and the silence count
      sys_rst = 1; tick();
      `CHK("commErr", 1'b0, commErr_r)
      `CHK("lineQuiet", 1'b0, lineQuiet)
      `CHK("txReady", 1'b1, txReady)
      sys_rst = 0;
      $display("test clear and reset done");
      fr = {8'h01}; rxFrame(0, 0);
      fr = {}; rxFrame(1, 0);
      repeat (24) begin
         mode = $urandom % 2; n = 1 + $urandom % 8; bad = ($urandom % 4) == 0;
         d = {};
         repeat (n) d.push_back(8'($urandom));
         mk(mode, bad); rxFrame(mode, !bad);
         txFrame(mode);
      end
      complete_run();
   end
endmodule // sfc_frame_check_tb
